//--- rtl/frs_pkg.sv
// Purpose: shared constants for result status and opcode decode
// Assumes: byte-wide status and command paths
// Notes: bit positions of the three status bytes and opcode patterns
package frs_pkg;
  // ---------------------------------------------------------------
  // status byte bit positions
  // ---------------------------------------------------------------
  localparam int ES1_MAM = 0;
  localparam int ES1_WP = 1;
  localparam int ES1_MD = 2;
  localparam int ES1_OR = 4;
  localparam int ES1_CRC = 5;
  localparam int ES1_EOT = 7;
  localparam int ES2_MAL = 0;
  localparam int ES2_BT = 1;
  localparam int ES2_SNS = 2;
  localparam int ES2_SS = 3;
  localparam int ES2_WT = 4;
  localparam int ES2_CDF = 5;
  localparam int ES2_CM = 6;
  localparam int DS3_HD = 2;
  localparam int DS3_T0 = 4;
  localparam int DS3_WP = 6;
  localparam logic [7:0] DS3_FIXED = 8'h28;
  localparam logic [7:0] BAD_TRACK_NUM = 8'hff;
  localparam logic [7:0] INVALID_STATUS = 8'h80;
  localparam logic [1:0] IC_INVALID = 2'h2;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // ---------------------------------------------------------------
  // opcode patterns
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_CONFIGURE = 8'h13;
  localparam logic [7:0] OP_DUMP = 8'h0e;
  localparam logic [7:0] OP_MODE = 8'h01;
  localparam logic [7:0] OP_IDENT = 8'h18;
  localparam logic [7:0] OP_PERP = 8'h12;
  localparam logic [7:0] OP_SPECIFY = 8'h03;
  localparam logic [7:0] OP_VERSION = 8'h10;
  localparam logic [6:0] OP_LOCK_LO = 7'h14;
  localparam logic [4:0] OP_READ_LO = 5'h06;
  localparam logic [4:0] OP_RDEL_LO = 5'h0c;
  localparam logic [4:0] OP_VERIFY_LO = 5'h16;
  localparam logic [4:0] OP_SCEQ_LO = 5'h11;
  localparam logic [4:0] OP_SCLE_LO = 5'h19;
  localparam logic [4:0] OP_SCHE_LO = 5'h1d;
  localparam logic [5:0] OP_WRITE_LO = 6'h05;
  localparam logic [5:0] OP_WDEL_LO = 6'h09;
  localparam logic [5:0] OP_FORMAT_LO = 6'h0d;
  localparam logic [5:0] OP_RDID_LO = 6'h0a;
  localparam logic [5:0] OP_RTRK_LO = 6'h02;
  localparam logic [7:0] OP_RECAL = 8'h07;
  localparam logic [7:0] OP_SEEK = 8'h0f;
  localparam logic [7:0] OP_SENSE_DRV = 8'h04;
  localparam logic [7:0] OP_SENSE_INT = 8'h08;
  localparam logic [5:0] OP_RELSEEK_LO = 6'h0f;
  localparam logic [5:0] OP_SETTRK_LO = 6'h21;

  typedef enum logic [4:0] {
    FRS_CMD_INVALID = 5'h00, FRS_CMD_CONFIGURE = 5'h01,
    FRS_CMD_DUMP = 5'h02, FRS_CMD_MODE = 5'h03, FRS_CMD_IDENT = 5'h04,
    FRS_CMD_PERP = 5'h05, FRS_CMD_SPECIFY = 5'h06,
    FRS_CMD_VERSION = 5'h07, FRS_CMD_LOCK = 5'h08, FRS_CMD_READ = 5'h09,
    FRS_CMD_RDEL = 5'h0a, FRS_CMD_VERIFY = 5'h0b, FRS_CMD_SCEQ = 5'h0c,
    FRS_CMD_SCLE = 5'h0d, FRS_CMD_SCHE = 5'h0e, FRS_CMD_WRITE = 5'h0f,
    FRS_CMD_WDEL = 5'h10, FRS_CMD_FORMAT = 5'h11, FRS_CMD_RDID = 5'h12,
    FRS_CMD_RTRK = 5'h13, FRS_CMD_RECAL = 5'h14, FRS_CMD_SEEK = 5'h15,
    FRS_CMD_SENSE_DRV = 5'h16, FRS_CMD_SENSE_INT = 5'h17,
    FRS_CMD_RELSEEK = 5'h18, FRS_CMD_SETTRK = 5'h19
  } frs_cmd_t;

  typedef enum logic [1:0] {
    FRS_IDLE = 2'b00, FRS_EXEC = 2'b01, FRS_RESULT = 2'b10
  } frs_state_t;
endpackage

//--- rtl/frs_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: asynchronous level input
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module frs_sync (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_async,
  output logic o_level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_level <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      o_level <= s3_reg;
    end
  end
endmodule
`default_nettype wire

//--- rtl/frs_decode.sv
// Purpose: first command byte to command type
// Assumes: host drives fixed opcode bits as documented
// Notes: pure combinational decode
`timescale 1ns/1ps
`default_nettype none
module frs_decode (
  input wire logic [7:0] i_opcode,
  output frs_pkg::frs_cmd_t o_cmd
);
  import frs_pkg::*;

  always_comb begin
    o_cmd = FRS_CMD_INVALID;
    case (i_opcode)
      OP_CONFIGURE: o_cmd = FRS_CMD_CONFIGURE;
      OP_DUMP: o_cmd = FRS_CMD_DUMP;
      OP_MODE: o_cmd = FRS_CMD_MODE;
      OP_IDENT: o_cmd = FRS_CMD_IDENT;
      OP_PERP: o_cmd = FRS_CMD_PERP;
      OP_SPECIFY: o_cmd = FRS_CMD_SPECIFY;
      OP_VERSION: o_cmd = FRS_CMD_VERSION;
      OP_RECAL: o_cmd = FRS_CMD_RECAL;
      OP_SEEK: o_cmd = FRS_CMD_SEEK;
      OP_SENSE_DRV: o_cmd = FRS_CMD_SENSE_DRV;
      OP_SENSE_INT: o_cmd = FRS_CMD_SENSE_INT;
      default: o_cmd = FRS_CMD_INVALID;
    endcase
    if (i_opcode[6:0] == OP_LOCK_LO) o_cmd = FRS_CMD_LOCK;
    case (i_opcode[4:0])
      OP_READ_LO: o_cmd = FRS_CMD_READ;
      OP_RDEL_LO: o_cmd = FRS_CMD_RDEL;
      OP_VERIFY_LO: o_cmd = FRS_CMD_VERIFY;
      OP_SCEQ_LO: o_cmd = FRS_CMD_SCEQ;
      OP_SCLE_LO: o_cmd = FRS_CMD_SCLE;
      OP_SCHE_LO: o_cmd = FRS_CMD_SCHE;
      default: ;
    endcase
    case (i_opcode[5:0])
      OP_WRITE_LO: o_cmd = FRS_CMD_WRITE;
      OP_WDEL_LO: o_cmd = FRS_CMD_WDEL;
      default: ;
    endcase
    if (!i_opcode[7]) begin
      case (i_opcode[5:0])
        OP_FORMAT_LO: o_cmd = FRS_CMD_FORMAT;
        OP_RDID_LO: o_cmd = FRS_CMD_RDID;
        OP_RTRK_LO: o_cmd = FRS_CMD_RTRK;
        OP_SETTRK_LO: o_cmd = FRS_CMD_SETTRK;
        default: ;
      endcase
    end
    if (i_opcode[7] && i_opcode[5:0] == OP_RELSEEK_LO) begin
      o_cmd = FRS_CMD_RELSEEK;
    end
  end
endmodule
`default_nettype wire

//--- rtl/frs_status.sv
// Purpose: result status bytes and opcode classification
// Assumes: execution engine reports events as one-cycle pulses
// Notes: status bytes leave only through the result byte port
`timescale 1ns/1ps
`default_nettype none
module frs_status (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_opcode_wr,
  input wire logic [7:0] i_opcode,
  input wire logic i_cmd_done,
  input wire logic [1:0] i_drive_sel,
  input wire logic i_head_sel,
  input wire logic i_track_zero_input,
  input wire logic i_write_protect_n,
  input wire logic i_terminal_count_input,
  input wire logic i_ev_no_addr_mark,
  input wire logic i_ev_no_data_mark,
  input wire logic i_ev_sector_absent,
  input wire logic i_ev_id_all_crc,
  input wire logic i_ev_no_start,
  input wire logic i_ev_overrun,
  input wire logic i_ev_crc_addr,
  input wire logic i_ev_crc_data,
  input wire logic i_ev_last_byte,
  input wire logic i_ev_track_mismatch,
  input wire logic [7:0] i_rec_track,
  input wire logic [7:0] i_cmd_track,
  input wire logic i_ev_scan_equal,
  input wire logic i_ev_scan_unmet,
  input wire logic i_ev_deleted_mark,
  input wire logic i_ev_regular_mark,
  input wire logic [1:0] i_result_sel,
  output frs_pkg::frs_cmd_t o_cmd,
  output logic o_cmd_valid,
  output logic o_invalid,
  output logic o_result_phase,
  output logic [7:0] o_result_byte
);
  import frs_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic track_zero_input_s;
  logic wp_s;
  logic tc_s;
  frs_sync u_track_zero_input (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_async(i_track_zero_input), .o_level(track_zero_input_s));
  // inverted ahead of the sync so reset reads as unprotected
  frs_sync u_wp (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_async(!i_write_protect_n), .o_level(wp_s));
  frs_sync u_tc (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_async(i_terminal_count_input), .o_level(tc_s));

  // ---------------------------------------------------------------
  // opcode decode and phase
  // ---------------------------------------------------------------
  frs_cmd_t dec_cmd;
  frs_cmd_t cmd_reg;
  frs_state_t state_reg;
  logic invalid_reg;
  logic cmd_valid_reg;
  frs_decode u_dec (.i_opcode(i_opcode), .o_cmd(dec_cmd));

  // decode relies on exact fixed bits from the host
  logic accept;
  assign accept = i_opcode_wr && (state_reg == FRS_IDLE);

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_reg <= FRS_IDLE;
      cmd_reg <= FRS_CMD_INVALID;
      invalid_reg <= 1'b0;
      cmd_valid_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= accept;
      case (state_reg)
        FRS_IDLE: begin
          if (accept) begin
            cmd_reg <= dec_cmd;
            invalid_reg <= (dec_cmd == FRS_CMD_INVALID);
            // invalid skips execution entirely
            if (dec_cmd == FRS_CMD_INVALID) begin
              state_reg <= FRS_RESULT;
            end else begin
              state_reg <= FRS_EXEC;
            end
          end
        end
        FRS_EXEC: begin
          if (i_cmd_done) state_reg <= FRS_RESULT;
        end
        FRS_RESULT: begin
          if (i_cmd_done) state_reg <= FRS_IDLE;
        end
        default: state_reg <= FRS_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // command class helpers
  // ---------------------------------------------------------------
  logic is_read_like;
  logic is_write_like;
  logic is_scan;
  logic in_exec;
  assign is_scan = (cmd_reg == FRS_CMD_SCEQ) || (cmd_reg == FRS_CMD_SCLE) ||
    (cmd_reg == FRS_CMD_SCHE);
  assign is_read_like = (cmd_reg == FRS_CMD_READ) ||
    (cmd_reg == FRS_CMD_RDEL) || (cmd_reg == FRS_CMD_VERIFY) || is_scan;
  assign is_write_like = (cmd_reg == FRS_CMD_WRITE) ||
    (cmd_reg == FRS_CMD_WDEL) || (cmd_reg == FRS_CMD_FORMAT);
  assign in_exec = (state_reg == FRS_EXEC);

  // ---------------------------------------------------------------
  // drive selection latched at end of command phase
  // ---------------------------------------------------------------
  logic [1:0] drive_reg;
  logic head_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      drive_reg <= 2'h0;
      head_reg <= 1'b0;
    end else if (state_reg == FRS_IDLE && accept) begin
      drive_reg <= i_drive_sel;
      head_reg <= i_head_sel;
    end
  end

  // ---------------------------------------------------------------
  // error flags sticky except ES1 write protect, which follows the pin in write-like exec,
  // and ES2 CDF, cleared by an address crc without a data crc; the clear on accept wins over any set in that cycle
  // ---------------------------------------------------------------
  logic [7:0] es1_reg;
  logic [7:0] es2_reg;
  logic [7:0] es1_set;
  logic [7:0] es2_set;
  logic tc_seen_reg;
  always_comb begin
    es1_set = ZERO_BYTE;
    es2_set = ZERO_BYTE;
    if (in_exec) begin
      es1_set[ES1_MAM] = is_read_like &&
        (i_ev_no_addr_mark || i_ev_no_data_mark);
      es1_set[ES1_MD] = i_ev_sector_absent || i_ev_id_all_crc ||
        i_ev_no_start;
      es1_set[ES1_OR] = i_ev_overrun;
      es1_set[ES1_CRC] = i_ev_crc_addr || i_ev_crc_data;
      es1_set[ES1_EOT] = i_ev_last_byte && !tc_seen_reg && !tc_s;
      es2_set[ES2_MAL] = is_read_like && i_ev_no_data_mark;
      es2_set[ES2_BT] = i_ev_sector_absent && i_ev_track_mismatch &&
        (i_rec_track == BAD_TRACK_NUM) &&
        (i_rec_track != i_cmd_track);
      es2_set[ES2_WT] = i_ev_sector_absent && i_ev_track_mismatch &&
        (i_rec_track != i_cmd_track);
      es2_set[ES2_SS] = is_scan && i_ev_scan_equal;
      es2_set[ES2_SNS] = is_scan && i_ev_scan_unmet;
      es2_set[ES2_CDF] = i_ev_crc_data;
      es2_set[ES2_CM] = ((cmd_reg == FRS_CMD_RDEL) && i_ev_regular_mark) ||
        (((cmd_reg == FRS_CMD_READ) || is_scan) &&
        i_ev_deleted_mark);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || accept) begin
      tc_seen_reg <= 1'b0;
    end else if (in_exec && tc_s) begin
      tc_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      es1_reg <= ZERO_BYTE;
      es2_reg <= ZERO_BYTE;
    end else if (accept) begin
      es1_reg <= ZERO_BYTE;
      es2_reg <= ZERO_BYTE;
    end else begin
      es1_reg <= es1_reg | es1_set;
      // address field crc without a data field crc in the same cycle clears the data field indicator
      if (in_exec && i_ev_crc_addr && !i_ev_crc_data) begin
        es2_reg <= (es2_reg | es2_set) & ~(8'h01 << ES2_CDF);
      end else begin
        es2_reg <= es2_reg | es2_set;
      end
      if (in_exec && is_write_like) begin
        es1_reg[ES1_WP] <= wp_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // assembled bytes with fixed bits
  // ---------------------------------------------------------------
  logic [7:0] es1_view;
  logic [7:0] es2_view;
  logic [7:0] ds3_view;
  logic [7:0] st0_view;
  // unused positions forced low whatever the flags hold
  localparam logic [7:0] ES1_USED = 8'hb7;
  localparam logic [7:0] ES2_USED = 8'h7f;
  always_comb begin
    es1_view = es1_reg & ES1_USED;
    es2_view = es2_reg & ES2_USED;
    ds3_view = DS3_FIXED;
    ds3_view[1:0] = drive_reg;
    ds3_view[DS3_HD] = head_reg;
    ds3_view[DS3_T0] = track_zero_input_s;
    ds3_view[DS3_WP] = wp_s;
    st0_view = {2'h0, 3'h0, head_reg, drive_reg};
    if (invalid_reg) st0_view = INVALID_STATUS;
  end

  // ---------------------------------------------------------------
  // result port, only live in the result phase
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_result_byte <= ZERO_BYTE;
    end else if (state_reg == FRS_RESULT) begin
      case (i_result_sel)
        2'h0: o_result_byte <= st0_view;
        2'h1: o_result_byte <= es1_view;
        2'h2: o_result_byte <= es2_view;
        default: o_result_byte <= ds3_view;
      endcase
    end else begin
      o_result_byte <= ZERO_BYTE;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_cmd <= FRS_CMD_INVALID;
      o_cmd_valid <= 1'b0;
      o_invalid <= 1'b0;
      o_result_phase <= 1'b0;
    end else begin
      o_cmd <= cmd_reg;
      o_cmd_valid <= cmd_valid_reg;
      o_invalid <= invalid_reg;
      o_result_phase <= (state_reg == FRS_RESULT);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence invalid_accept_s;
    accept && (dec_cmd == FRS_CMD_INVALID);
  endsequence
  sequence result_entry_s;
    ##1 (state_reg == FRS_RESULT) ##1 o_result_phase;
  endsequence
  invalid_to_result_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) invalid_accept_s |-> result_entry_s)
    else $error("invalid opcode did not reach result phase");
  invalid_code_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst)
    (state_reg == FRS_RESULT) && invalid_reg && (i_result_sel == 2'h0)
    |=> o_result_byte == INVALID_STATUS)
    else $error("invalid status byte not 80h");
  flags_cleared_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) accept |=> (es1_reg == 8'h00) &&
    (es2_reg == 8'h00))
    else $error("flags not cleared on new opcode");
  es1_fixed_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) (state_reg == FRS_RESULT) &&
    (i_result_sel == 2'h1) |=> (o_result_byte & 8'h48) == 8'h00)
    else $error("first error byte fixed bits wrong");
  ds3_fixed_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) (state_reg == FRS_RESULT) &&
    (i_result_sel == 2'h3) |=> (o_result_byte & 8'ha8) == 8'h28)
    else $error("drive status fixed bits wrong");
  overrun_flag_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) in_exec && i_ev_overrun && !accept
    |=> es1_reg[ES1_OR])
    else $error("overrun not recorded");
  wrong_track_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) in_exec && i_ev_sector_absent &&
    i_ev_track_mismatch && (i_rec_track != i_cmd_track) && !accept
    |=> es2_reg[ES2_WT])
    else $error("wrong track not recorded");
  scan_equal_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) in_exec && is_scan && i_ev_scan_equal &&
    !accept |=> es2_reg[ES2_SS])
    else $error("scan equal not recorded");
  drive_latch_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) accept |=> drive_reg == $past(i_drive_sel))
    else $error("drive select not latched");
  wp_track_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) (state_reg == FRS_RESULT) &&
    (i_result_sel == 2'h3) |=> o_result_byte[DS3_WP] == $past(wp_s))
    else $error("write protect bit wrong");
  result_only_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) (state_reg != FRS_RESULT)
    |=> o_result_byte == 8'h00)
    else $error("status visible outside result phase");
  missing_mark_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) in_exec && is_read_like &&
    i_ev_no_addr_mark |=> es1_reg[ES1_MAM])
    else $error("missing address mark not recorded");
  wp_write_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) in_exec && is_write_like
    |=> es1_reg[ES1_WP] == $past(wp_s))
    else $error("write protect error bit wrong");
  missing_data_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) in_exec && (i_ev_sector_absent ||
    i_ev_id_all_crc || i_ev_no_start) |=> es1_reg[ES1_MD])
    else $error("missing data not recorded");
  crc_field_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) in_exec && i_ev_crc_addr && !i_ev_crc_data
    |=> es1_reg[ES1_CRC] && !es2_reg[ES2_CDF])
    else $error("address field crc reported wrongly");
  eot_flag_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) in_exec && i_ev_last_byte && !tc_seen_reg &&
    !tc_s |=> es1_reg[ES1_EOT])
    else $error("end of track not recorded");
  mark_place_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) in_exec && is_read_like && i_ev_no_data_mark
    |=> es1_reg[ES1_MAM] && es2_reg[ES2_MAL])
    else $error("data mark location not recorded");
  bad_track_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) in_exec && i_ev_sector_absent &&
    i_ev_track_mismatch && (i_rec_track == BAD_TRACK_NUM) &&
    (i_rec_track != i_cmd_track) |=> es2_reg[ES2_BT])
    else $error("bad track not recorded");
  control_mark_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) in_exec && (cmd_reg == FRS_CMD_RDEL) &&
    i_ev_regular_mark |=> es2_reg[ES2_CM])
    else $error("control mark not recorded");
  track_zero_input_bit_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) (state_reg == FRS_RESULT) &&
    (i_result_sel == 2'h3) |=> o_result_byte[DS3_T0] == $past(track_zero_input_s))
    else $error("track zero bit wrong");
  head_latch_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) accept |=> head_reg == $past(i_head_sel))
    else $error("head select not latched");
  cmd_valid_a: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst) accept |=> cmd_valid_reg ##1 o_cmd_valid)
    else $error("command valid pulse missing");
endmodule
`default_nettype wire

//--- verification/frs_host.sv
// Purpose: host model issuing opcodes and reading result bytes
// Assumes: result byte is registered one cycle after select
// Notes: drives on falling edges only
`timescale 1ns/1ps
`default_nettype none
module frs_host (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_result_byte,
  output logic o_opcode_wr,
  output logic [7:0] o_opcode,
  output logic o_cmd_done,
  output logic [1:0] o_result_sel
);
  initial begin
    o_opcode_wr = 1'b0;
    o_opcode = 8'h00;
    o_cmd_done = 1'b0;
    o_result_sel = 2'h0;
  end
  // ---------------------------------------------------------------
  // opcode strobe, fixed bits passed through untouched
  // ---------------------------------------------------------------
  task automatic send_op(input logic [7:0] op);
    @(negedge i_sys_clk);
    o_opcode_wr = 1'b1;
    o_opcode = op;
    @(negedge i_sys_clk);
    o_opcode_wr = 1'b0;
    o_opcode = ~op; // stale value would hide a late sample
  endtask
  task automatic pulse_done();
    @(negedge i_sys_clk);
    o_cmd_done = 1'b1;
    @(negedge i_sys_clk);
    o_cmd_done = 1'b0;
  endtask
  // ---------------------------------------------------------------
  // result read: select, one edge, then take the byte
  // ---------------------------------------------------------------
  task automatic read_res(input logic [1:0] sel, output logic [7:0] b);
    @(negedge i_sys_clk);
    o_result_sel = sel;
    @(negedge i_sys_clk);
    b = i_result_byte;
  endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
// Purpose: self-checking bench for result status and opcode decode
// Assumes: status block contract of one-cycle event pulses
// Notes: pins synchronised, so waits of six cycles follow pin changes
`timescale 1ns/1ps
`default_nettype none
module tb;
  import frs_pkg::*;
  logic clk, rst, wr, done, hd, track_zero_input, wp_n, tc, cv, inv, rph;
  logic [1:0] dsel, rsel;
  logic [7:0] op, rb, b, rtrk, ctrk;
  logic [13:0] ev;
  frs_cmd_t cmd;
  int failures = 0;
  int tests_run = 0;
  frs_host host (.i_sys_clk(clk), .i_result_byte(rb), .o_opcode_wr(wr),
    .o_opcode(op), .o_cmd_done(done), .o_result_sel(rsel));
  frs_status uut (.i_sys_clk(clk), .i_sys_rst(rst), .i_opcode_wr(wr),
    .i_opcode(op), .i_cmd_done(done), .i_drive_sel(dsel),
    .i_head_sel(hd), .i_track_zero_input(track_zero_input),
    .i_write_protect_n(wp_n), .i_terminal_count_input(tc),
    .i_ev_no_addr_mark(ev[0]), .i_ev_no_data_mark(ev[1]),
    .i_ev_sector_absent(ev[2]), .i_ev_id_all_crc(ev[3]),
    .i_ev_no_start(ev[4]), .i_ev_overrun(ev[5]), .i_ev_crc_addr(ev[6]),
    .i_ev_crc_data(ev[7]), .i_ev_last_byte(ev[8]),
    .i_ev_track_mismatch(ev[9]), .i_rec_track(rtrk),
    .i_cmd_track(ctrk), .i_ev_scan_equal(ev[10]),
    .i_ev_scan_unmet(ev[11]), .i_ev_deleted_mark(ev[12]),
    .i_ev_regular_mark(ev[13]), .i_result_sel(rsel), .o_cmd(cmd),
    .o_cmd_valid(cv), .o_invalid(inv), .o_result_phase(rph),
    .o_result_byte(rb));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // compare and verdict
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_cmd(input frs_cmd_t got, input frs_cmd_t exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: cmd %h not %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one command: opcode, events in exec, into result phase
  task automatic run_cmd(input logic [7:0] o, input logic [13:0] e);
    host.send_op(o);
    @(negedge clk);
    chk({7'h00, cv}, 8'h01);
    ev = e;
    @(negedge clk);
    chk({7'h00, cv}, 8'h00);
    ev = 14'h0;
    host.pulse_done();
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // ---------------------------------------------------------------
  // tables
  // ---------------------------------------------------------------
  logic [7:0] dops [25] = '{8'h13, 8'h0e, 8'h01, 8'h18, 8'h12, 8'h03,
    8'h10, 8'h94, 8'hc6, 8'h4c, 8'h36, 8'h11, 8'h19, 8'h1d, 8'h85,
    8'h49, 8'h4d, 8'h0a, 8'h42, 8'h07, 8'h0f, 8'h04, 8'h08, 8'hcf,
    8'h21};
  logic [7:0] eops [14] = '{8'h06, 8'h06, 8'h06, 8'h0a, 8'h02, 8'h06,
    8'h06, 8'h06, 8'h06, 8'h11, 8'h1d, 8'h06, 8'h0c, 8'h06};
  logic [13:0] evs [14] = '{14'h0001, 14'h0002, 14'h0204, 14'h0008,
    14'h0010, 14'h0020, 14'h0080, 14'h0040, 14'h0100, 14'h0400,
    14'h0800, 14'h1000, 14'h2000, 14'h0000};
  logic [7:0] ex1 [14] = '{8'h01, 8'h01, 8'h04, 8'h04, 8'h04, 8'h10,
    8'h20, 8'h20, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ex2 [14] = '{8'h00, 8'h01, 8'h12, 8'h00, 8'h00, 8'h00,
    8'h20, 8'h00, 8'h00, 8'h08, 8'h04, 8'h40, 8'h40, 8'h00};
  initial begin
    rst = 1'b1;
    ev = 14'h0;
    dsel = 2'h0;
    hd = 1'b0;
    track_zero_input = 1'b0;
    wp_n = 1'b1;
    tc = 1'b0;
    rtrk = 8'hff;
    ctrk = 8'h05;
    wait_n(13);
    rst = 1'b0;
    // invalid opcode goes straight to result with 80h
    host.send_op(8'hff);
    wait_n(1);
    chk({7'h00, rph & inv}, 8'h01);
    host.read_res(2'h0, b);
    chk(b, INVALID_STATUS);
    host.pulse_done();
    wait_n(2);
    chk(rb, ZERO_BYTE);
    $display("test invalid opcode done");
    for (int i = 0; i < 25; i++) begin
      run_cmd(dops[i], 14'h0);
      chk_cmd(cmd, frs_cmd_t'(i + 1));
      host.pulse_done();
    end
    wait_n(1);
    chk({6'h00, inv, rph}, 8'h00);
    $display("test decode done");
    for (int i = 0; i < 14; i++) begin
      run_cmd(eops[i], evs[i]);
      host.read_res(2'h1, b);
      chk(b, ex1[i]);
      host.read_res(2'h2, b);
      chk(b, ex2[i]);
      host.pulse_done();
    end
    rtrk = 8'h07;
    run_cmd(8'h06, 14'h0204);
    host.read_res(2'h2, b);
    chk(b, 8'h10);
    host.pulse_done();
    rtrk = 8'hff;
    host.send_op(8'h06);
    @(negedge clk);
    ev = 14'h0080;
    @(negedge clk);
    ev = 14'h0040;
    @(negedge clk);
    ev = 14'h0;
    host.pulse_done();
    host.read_res(2'h2, b);
    chk(b, 8'h00);
    host.read_res(2'h1, b);
    chk(b, 8'h20);
    host.pulse_done();
    $display("test error flags done");
    // terminal count seen: no end-of-track flag
    tc = 1'b1;
    wait_n(6);
    run_cmd(8'h06, 14'h0100);
    host.read_res(2'h1, b);
    chk(b, 8'h00);
    host.pulse_done();
    tc = 1'b0;
    $display("test terminal count done");
    // drive status with protected write and latched drive and head
    dsel = 2'h3; hd = 1'b1; track_zero_input = 1'b1; wp_n = 1'b0;
    wait_n(6);
    run_cmd(8'h45, 14'h0);
    host.read_res(2'h1, b);
    chk(b, 8'h02);
    host.read_res(2'h3, b);
    chk(b, 8'h7f);
    host.pulse_done();
    dsel = 2'h2; hd = 1'b0; track_zero_input = 1'b0; wp_n = 1'b1;
    wait_n(6);
    run_cmd(8'h05, 14'h0);
    host.read_res(2'h1, b);
    chk(b, 8'h00);
    host.read_res(2'h3, b);
    chk(b, 8'h2a);
    chk({7'h00, rph}, 8'h01);
    host.pulse_done();
    $display("test drive status done");
    // invalid after a valid command must replace the old decode
    host.send_op(8'h1f);
    host.read_res(2'h0, b);
    chk(b, INVALID_STATUS);
    chk_cmd(cmd, FRS_CMD_INVALID);
    host.pulse_done();
    $display("test invalid after valid done");
    print_verdict();
  end
  // hang guard: whole run is well under this span
  initial begin
    #200000;
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
